// *** logic/timer_defines.svh ***
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ==========================================
// register byte offsets on apb
`define OFF_STATUS 8'h00
`define OFF_CNT_HI 8'h04
`define OFF_CNT_LO 8'h08
`define OFF_MOD_HI 8'h0c
`define OFF_MOD_LO 8'h10
`define OFF_CH_FLAGS 8'h14
`define OFF_CH_IRQ_EN 8'h18
`define OFF_CH_MODE 8'h1c

// ==========================================
// status and control field positions
`define BIT_OVF 7
`define BIT_OVF_IE 6
`define BIT_HALT 5
`define BIT_CLR 4
`define SEL_HI 2
`define SEL_LO 0

// ==========================================
// channel mode field positions
`define CH_CMP_HI 5
`define CH_CMP_LO 0
`define CH_BUF_HI 8
`define CH_BUF_LO 6

// ==========================================
// reset values
`define RST_MOD 16'hffff
`define RST_HALT 1'h1
`define RST_OVF_IE 1'h0
`define RST_SEL 3'h0

`endif

// *** logic/timer_pkg.sv ***
package timer_pkg;

  typedef enum logic [2:0] {
    DIV1 = 3'h0,
    DIV2 = 3'h1,
    DIV4 = 3'h2,
    DIV8 = 3'h3,
    DIV16 = 3'h4,
    DIV32 = 3'h5,
    DIV64 = 3'h6,
    EXT_PIN = 3'h7
  } clock_select_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ANSWER = 2'h1
  } bus_state_type;

endpackage

// *** logic/prescaler.sv ***
`timescale 1ns/1ns

module prescaler (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic run,
  input wire timer_pkg::clock_select_type select,
  input wire logic ext_pin,
  output logic tick
);

  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic [5:0] div_q;
  logic ext_rise;

  // ==========================================
  // external pin synchroniser
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_meta_q <= 1'h0;
      ext_sync_q <= 1'h0;
      ext_prev_q <= 1'h0;
    end
    else if (clk_en)
    begin
      ext_meta_q <= ext_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  assign ext_rise = ext_sync_q & ~ext_prev_q;

  // ==========================================
  // divider chain
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      div_q <= 6'h00;
    else if (clk_en)
    begin
      if (clear)
        div_q <= 6'h00;
      else if (run)
        div_q <= div_q + 6'h01;
    end
  end

  // pin edges need two bus clocks of width to be seen
  always_comb
  begin
    case (select)
      timer_pkg::DIV1: tick = 1'h1; // R10
      timer_pkg::DIV2: tick = div_q[0];
      timer_pkg::DIV4: tick = &div_q[1:0];
      timer_pkg::DIV8: tick = &div_q[2:0];
      timer_pkg::DIV16: tick = &div_q[3:0];
      timer_pkg::DIV32: tick = &div_q[4:0];
      timer_pkg::DIV64: tick = &div_q[5:0];
      timer_pkg::EXT_PIN: tick = ext_rise; // R10
      default: tick = 1'h0;
    endcase
    tick = tick & run & ~clear;
  end

endmodule // prescaler

// *** logic/channel_flags.sv ***
`timescale 1ns/1ns

module channel_flags (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [5:0] capture_event,
  input wire logic [5:0] compare_event,
  input wire logic [5:0] compare_mode,
  input wire logic [5:0] channel_active,
  input wire logic capture_inhibit,
  input wire logic read_arm,
  input wire logic write_clear,
  input wire logic [5:0] clear_data,
  output logic [5:0] flags
);

  // ==========================================
  // per channel sticky flag with two step clear
  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_chan
      logic event_hit;
      logic arm_q;
      logic flag_q;

      assign event_hit = channel_active[i] & (compare_mode[i] ? compare_event[i] :
                         (capture_event[i] & ~capture_inhibit)); // R4

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          arm_q <= 1'h0;
        else if (clk_en)
        begin
          if (event_hit)
            arm_q <= 1'h0;
          else if (read_arm && flag_q)
            arm_q <= 1'h1;
          else if (write_clear)
            arm_q <= 1'h0;
        end
      end

      // set wins over a clear in the same cycle
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          flag_q <= 1'h0;
        else if (clk_en)
        begin
          if (event_hit)
            flag_q <= 1'h1; // R4
          else if (write_clear && !clear_data[i] && arm_q)
            flag_q <= 1'h0;
        end
      end

      assign flags[i] = flag_q;
    end
  endgenerate

endmodule // channel_flags

// *** logic/modulo_timer_control.sv ***
`timescale 1ns/1ns
`include "timer_defines.svh"

// Operation
// (R1) overflow flag sets when the counter reaches the modulo value
// (R2) after reaching modulo, counter restarts from zero on next timer clock
// (R3) overflow request only while flag set and its enable is one
// (R4) six channel flags set on capture or compare, request when enabled
// (R5) flag clears by read-then-write-zero; new overflow voids it; one ignored
// (R6) halt bit holds the counter; reset sets it
// (R7) halt inhibits input captures
// (R8) write-only clear bit zeroes counter and prescaler, reads zero
// (R9) halt and clear written together leave counter stopped at zero
// (R10) three-bit select picks bus divide 1 to 64 or external pin
// (R11) external pin forced to input while selected
// (R12) high byte read buffers low byte until low byte is read
// (R13) reset and clear bit zero the counter
// (R14) modulo high write suppresses overflow until low byte written
// (R15) reset loads modulo with all ones
// (R16) software should clear counter before writing new modulo
// (R17) reset clears flag, enable, clear bit and select bits
// (R18) runs in wait; enabled requests wake; no register access in wait
// (R19) stop mode freezes timer keeping all state; channel flags here still set on captures and compares in stop
// (R20) break halts the counter and inhibits captures
// (R21) break without clear enable protects flags; with it, clears persist
// (R22) each channel capture or compare; channels 0, 2, 4 buffered
// (R23) counter advances one per enabled selected timer clock edge
module modulo_timer_control (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_timer_clock_pin,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_active,
  input wire logic break_clear_enable,
  input wire logic [5:0] channel_capture_event,
  input wire logic [5:0] channel_compare_event,
  output logic [15:0] count_value,
  output logic overflow_irq,
  output logic [5:0] channel_irq,
  output logic timer_irq,
  output logic ext_pin_force_input,
  output logic [5:0] channel_compare_mode,
  output logic [2:0] channel_buffered_mode
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  timer_pkg::bus_state_type bus_state_q;
  timer_pkg::clock_select_type clk_sel_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [15:0] count_q;
  logic [15:0] mod_q;
  logic [15:0] count_next;
  logic mod_hold_q;
  logic ovf_flag_q;
  logic ovf_arm_q;
  logic ovf_ie_q;
  logic halt_q;
  logic lo_latched_q;
  logic [7:0] lo_buf_q;
  logic [5:0] ch_ie_q;
  logic [5:0] ch_cmp_q;
  logic [2:0] ch_buf_q;
  logic [5:0] ch_flags;
  logic overflow_irq_q;
  logic [5:0] channel_irq_q;
  logic timer_irq_q;
  logic force_input_q;
  logic take;
  logic done;
  logic wr;
  logic rd_take;
  logic mapped;
  logic err_d;
  logic [7:0] rdata8;
  logic clr;
  logic run;
  logic tick;
  logic ovf_event;
  logic flag_access_ok;
  logic capture_inhibit;
  logic [5:0] ch_active;

  // ==========================================
  // apb slave, one wait state
  assign take = psel & penable & (bus_state_q == timer_pkg::BUS_IDLE);
  assign done = psel & penable & (bus_state_q == timer_pkg::BUS_ANSWER);
  assign mapped = hit(paddr, `OFF_STATUS) | hit(paddr, `OFF_CNT_HI) | hit(paddr, `OFF_CNT_LO) |
                  hit(paddr, `OFF_MOD_HI) | hit(paddr, `OFF_MOD_LO) |
                  hit(paddr, `OFF_CH_FLAGS) | hit(paddr, `OFF_CH_IRQ_EN) |
                  hit(paddr, `OFF_CH_MODE);
  assign err_d = ~mapped | wait_mode; // R18
  assign wr = done & pwrite & ~pslverr_q;
  assign rd_take = take & ~pwrite & ~err_d;

  always_comb
  begin
    rdata8 = 8'h00;
    case (paddr)
      `OFF_STATUS: rdata8 = {ovf_flag_q, ovf_ie_q, halt_q, 1'h0, 1'h0, clk_sel_q}; // R8
      `OFF_CNT_HI: rdata8 = count_q[15:8];
      `OFF_CNT_LO: rdata8 = lo_latched_q ? lo_buf_q : count_q[7:0]; // R12
      `OFF_MOD_HI: rdata8 = mod_q[15:8];
      `OFF_MOD_LO: rdata8 = mod_q[7:0];
      `OFF_CH_FLAGS: rdata8 = {2'h0, ch_flags};
      `OFF_CH_IRQ_EN: rdata8 = {2'h0, ch_ie_q};
      default: rdata8 = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_state_q <= timer_pkg::BUS_IDLE;
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      case (bus_state_q)
        timer_pkg::BUS_IDLE:
        begin
          if (take)
          begin
            bus_state_q <= timer_pkg::BUS_ANSWER;
            pready_q <= 1'h1;
            pslverr_q <= err_d;
            if (pwrite || err_d)
              prdata_q <= 32'h0000_0000;
            else if (hit(paddr, `OFF_CH_MODE))
              prdata_q <= {23'h0, ch_buf_q, ch_cmp_q};
            else
              prdata_q <= {24'h0, rdata8};
          end
        end
        timer_pkg::BUS_ANSWER:
        begin
          bus_state_q <= timer_pkg::BUS_IDLE;
          pready_q <= 1'h0;
          pslverr_q <= 1'h0;
        end
        default:
        begin
          bus_state_q <= timer_pkg::BUS_IDLE;
          pready_q <= 1'h0;
          pslverr_q <= 1'h0;
        end
      endcase
    end
  end

  // ==========================================
  // control register
  assign clr = wr & hit(paddr, `OFF_STATUS) & pwdata[`BIT_CLR]; // R8

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      halt_q <= `RST_HALT; // R6
      ovf_ie_q <= `RST_OVF_IE; // R17
      clk_sel_q <= timer_pkg::clock_select_type'(`RST_SEL); // R17
    end
    else if (clk_en && wr && hit(paddr, `OFF_STATUS))
    begin
      halt_q <= pwdata[`BIT_HALT]; // R9
      ovf_ie_q <= pwdata[`BIT_OVF_IE];
      clk_sel_q <= timer_pkg::clock_select_type'(pwdata[`SEL_HI:`SEL_LO]);
    end
  end

  // ==========================================
  // prescaler and counter
  // stop and break freeze the count and prescaler; channel flags still set in stop, and on compares in break
  assign run = ~halt_q & ~break_active & ~stop_mode; // R6 R19 R20

  prescaler u_prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .clear(clr),
    .run(run),
    .select(clk_sel_q),
    .ext_pin(ext_timer_clock_pin),
    .tick(tick)
  );

  assign count_next = (count_q == mod_q) ? 16'h0000 : count_q + 16'h0001; // R2
  assign ovf_event = tick & (count_next == mod_q) & ~mod_hold_q; // R14

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count_q <= 16'h0000; // R13
    else if (clk_en)
    begin
      if (clr)
        count_q <= 16'h0000; // R13
      else if (tick)
        count_q <= count_next; // R23
    end
  end

  // ==========================================
  // modulo registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mod_q <= `RST_MOD; // R15
      mod_hold_q <= 1'h0;
    end
    else if (clk_en && wr)
    begin
      if (hit(paddr, `OFF_MOD_HI))
      begin
        mod_q[15:8] <= pwdata[7:0];
        mod_hold_q <= 1'h1; // R14
      end
      else if (hit(paddr, `OFF_MOD_LO))
      begin
        mod_q[7:0] <= pwdata[7:0];
        mod_hold_q <= 1'h0; // R14
      end
    end
  end

  // ==========================================
  // overflow flag, two step clear
  assign flag_access_ok = ~break_active | break_clear_enable; // R21

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ovf_arm_q <= 1'h0;
    else if (clk_en)
    begin
      if (ovf_event)
        ovf_arm_q <= 1'h0; // R5
      else if (rd_take && hit(paddr, `OFF_STATUS) && ovf_flag_q && flag_access_ok)
        ovf_arm_q <= 1'h1;
      else if (wr && hit(paddr, `OFF_STATUS) && flag_access_ok)
        ovf_arm_q <= 1'h0;
    end
  end

  // a half-done clear survives break without clear enable; only a write after that break finishes it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ovf_flag_q <= 1'h0; // R17
    else if (clk_en)
    begin
      if (ovf_event)
        ovf_flag_q <= 1'h1; // R1
      else if (wr && hit(paddr, `OFF_STATUS) && !pwdata[`BIT_OVF] && ovf_arm_q &&
               flag_access_ok)
        ovf_flag_q <= 1'h0; // R5
    end
  end

  // ==========================================
  // low byte read buffer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lo_latched_q <= 1'h0;
      lo_buf_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (clr)
        lo_latched_q <= 1'h0;
      else if (rd_take && hit(paddr, `OFF_CNT_HI) && !lo_latched_q)
      begin
        lo_latched_q <= 1'h1; // R12
        lo_buf_q <= count_q[7:0];
      end
      else if (rd_take && hit(paddr, `OFF_CNT_LO))
        lo_latched_q <= 1'h0;
    end
  end

  // ==========================================
  // channel control and flags
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ch_ie_q <= 6'h00;
      ch_cmp_q <= 6'h00;
      ch_buf_q <= 3'h0;
    end
    else if (clk_en && wr)
    begin
      if (hit(paddr, `OFF_CH_IRQ_EN))
        ch_ie_q <= pwdata[5:0];
      if (hit(paddr, `OFF_CH_MODE))
      begin
        ch_cmp_q <= pwdata[`CH_CMP_HI:`CH_CMP_LO]; // R22
        ch_buf_q <= pwdata[`CH_BUF_HI:`CH_BUF_LO]; // R22
      end
    end
  end

  // odd channels go idle while their even partner runs buffered
  assign ch_active = ~{ch_buf_q[2], 1'h0, ch_buf_q[1], 1'h0, ch_buf_q[0], 1'h0}; // R22
  assign capture_inhibit = halt_q | break_active; // R7 R20

  channel_flags u_channel_flags (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .capture_event(channel_capture_event),
    .compare_event(channel_compare_event),
    .compare_mode(ch_cmp_q),
    .channel_active(ch_active),
    .capture_inhibit(capture_inhibit),
    .read_arm(rd_take & hit(paddr, `OFF_CH_FLAGS) & flag_access_ok),
    .write_clear(wr & hit(paddr, `OFF_CH_FLAGS) & flag_access_ok),
    .clear_data(pwdata[5:0]),
    .flags(ch_flags)
  );

  // ==========================================
  // requests and pin control
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      overflow_irq_q <= 1'h0;
      channel_irq_q <= 6'h00;
      timer_irq_q <= 1'h0;
      force_input_q <= 1'h0;
    end
    else if (clk_en)
    begin
      overflow_irq_q <= ovf_flag_q & ovf_ie_q; // R3
      channel_irq_q <= ch_flags & ch_ie_q; // R4
      timer_irq_q <= (ovf_flag_q & ovf_ie_q) | (|(ch_flags & ch_ie_q)); // R18
      force_input_q <= (clk_sel_q == timer_pkg::EXT_PIN); // R11
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign count_value = count_q;
  assign overflow_irq = overflow_irq_q;
  assign channel_irq = channel_irq_q;
  assign timer_irq = timer_irq_q;
  assign ext_pin_force_input = force_input_q;
  assign channel_compare_mode = ch_cmp_q;
  assign channel_buffered_mode = ch_buf_q;

  // ==========================================
  // assertions
  ovf_set_a: assert property (@(posedge clk) disable iff (!rst_b) // R1
    clk_en && ovf_event |=> ovf_flag_q) else $error("overflow flag not set");
  wrap_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // R2
    clk_en && tick && !clr && count_q == mod_q |=> count_q == 16'h0000)
    else $error("counter did not wrap to zero");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // R3
    clk_en && !(ovf_flag_q && ovf_ie_q) |=> !overflow_irq_q)
    else $error("ungated overflow request");
  ovf_one_a: assert property (@(posedge clk) disable iff (!rst_b) // R5
    clk_en && wr && hit(paddr, `OFF_STATUS) && pwdata[`BIT_OVF] |=>
    ovf_flag_q == $past(ovf_flag_q) || ovf_flag_q)
    else $error("writing one changed flag");
  halt_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R6
    clk_en && halt_q && !clr |=> $stable(count_q)) else $error("counter moved while halted");
  clear_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // R8
    clk_en && clr |=> count_q == 16'h0000 && u_prescaler.div_q == 6'h00)
    else $error("clear bit did not zero counter");
  halt_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // R9
    clk_en && clr && pwdata[`BIT_HALT] |=> (halt_q && count_q == 16'h0000) [*2])
    else $error("counter not stopped at zero");
  lo_buffer_a: assert property (@(posedge clk) disable iff (!rst_b) // R12
    clk_en && lo_latched_q && !(rd_take && hit(paddr, `OFF_CNT_LO)) && !clr
    |=> lo_latched_q && $stable(lo_buf_q)) else $error("buffered low byte changed");
  mod_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R14
    clk_en && mod_hold_q && !ovf_flag_q |=> !ovf_flag_q)
    else $error("overflow during modulo update");
  break_count_a: assert property (@(posedge clk) disable iff (!rst_b) // R20
    clk_en && break_active && !clr |=> $stable(count_q)) else $error("counter moved in break");
  break_flag_a: assert property (@(posedge clk) disable iff (!rst_b) // R21
    clk_en && break_active && !break_clear_enable && ovf_flag_q |=> ovf_flag_q)
    else $error("flag cleared during protected break");
  force_input_a: assert property (@(posedge clk) disable iff (!rst_b) // R11
    clk_en && clk_sel_q == timer_pkg::EXT_PIN |=> ext_pin_force_input)
    else $error("pin not forced");

  ovf_seen_c: cover property (@(posedge clk) disable iff (!rst_b) ovf_event ##1 overflow_irq_q);
  ovf_clear_c: cover property (@(posedge clk) disable iff (!rst_b)
    ovf_flag_q ##[1:40] !ovf_flag_q);
  lo_latch_c: cover property (@(posedge clk) disable iff (!rst_b)
    !lo_latched_q ##1 lo_latched_q ##[1:20] !lo_latched_q);

endmodule // modulo_timer_control

// *** dv/tb_modulo_timer_control.sv ***
`timescale 1ns/1ns
`include "timer_defines.svh"

module tb_modulo_timer_control;
  logic clk;
  logic rst_b;
  logic clk_en;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_pin;
  logic wait_mode;
  logic stop_mode;
  logic brk;
  logic bce;
  logic [5:0] cap_ev;
  logic [5:0] cmp_ev;
  logic [15:0] count_value;
  logic overflow_irq;
  logic [5:0] channel_irq;
  logic timer_irq;
  logic force_in;
  logic [5:0] cmp_mode;
  logic [2:0] buf_mode;
  logic [31:0] rdata;
  logic err;
  logic [15:0] snap;
  logic [5:0] mode;
  logic [5:0] exp_fl;
  int n_fail;
  int check_count;
  int cycles;
  int ext_div;
  int gap;
  int m;
  int seq_q[$];

  modulo_timer_control uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_timer_clock_pin(ext_pin),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .break_active(brk),
    .break_clear_enable(bce), .channel_capture_event(cap_ev),
    .channel_compare_event(cmp_ev), .count_value(count_value), .overflow_irq(overflow_irq),
    .channel_irq(channel_irq), .timer_irq(timer_irq), .ext_pin_force_input(force_in),
    .channel_compare_mode(cmp_mode), .channel_buffered_mode(buf_mode));

  // ==========================================
  // clock, external pin and watchdog
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // pin period of 8 bus cycles keeps well inside the synchroniser limit
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    ext_div <= (ext_div + 1) % 4;
    if (ext_div == 3)
      ext_pin <= ~ext_pin;
    if (cycles == 30000)
    begin
      n_fail++;
      results();
    end
  end

  // ==========================================
  // checking and bus tasks
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // waits on pready with no assumed latency; watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // clears counter and prescaler, then times two successive increments
  task automatic interval(input logic [2:0] k);
    logic [15:0] prev;
    int t0;
    wr(`OFF_STATUS, {24'h0, 5'h6, k});
    wr(`OFF_STATUS, {24'h0, 5'h0, k});
    prev = count_value;
    t0 = -1;
    gap = 0;
    for (int n = 0; n < 400 && gap == 0; n++)
    begin
      @(posedge clk);
      if (count_value !== prev)
      begin
        if (t0 >= 0)
          gap = cycles - t0;
        t0 = cycles;
        prev = count_value;
      end
    end
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    {rst_b, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_pin, wait_mode, stop_mode, brk, bce, cap_ev, cmp_ev} = '0;
    {n_fail, check_count, cycles, ext_div} = '0;
    void'($urandom(32'h3f993aae));
    clk_en = 1'b1;
    cyc(4);
    rst_b <= 1'b1;
    rd(`OFF_STATUS, 32'h20);
    rd(`OFF_MOD_HI, 32'hff);
    rd(`OFF_MOD_LO, 32'hff);
    rd(`OFF_CNT_HI, 32'h0);
    rd(`OFF_CNT_LO, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      interval(k[2:0]);
      chk(gap, (k == 7) ? 8 : (1 << k));
      chk(force_in, k == 7);
    end
    m = $urandom_range(9, 2);
    wr(`OFF_STATUS, 32'h70);
    wr(`OFF_MOD_HI, 32'h0);
    wr(`OFF_MOD_LO, m);
    cyc(3);
    chk(count_value, 16'h0);
    wr(`OFF_STATUS, 32'h40);
    for (int i = 0; i < 40; i++)
      seq_q.push_back((i + 1) % (m + 1));
    snap = 16'h0;
    for (int i = 0; i < 100 && seq_q.size() > 0; i++)
    begin
      @(posedge clk);
      if (count_value !== snap)
      begin
        chk(count_value, seq_q.pop_front());
        snap = count_value;
      end
    end
    wr(`OFF_STATUS, 32'h60);
    cyc(2);
    rd(`OFF_STATUS, 32'he0);
    chk(overflow_irq, 1'b1);
    chk(timer_irq, 1'b1);
    wr(`OFF_STATUS, 32'ha0);
    cyc(2);
    rd(`OFF_STATUS, 32'ha0);
    chk(overflow_irq, 1'b0);
    wr(`OFF_STATUS, 32'h20);
    rd(`OFF_STATUS, 32'h20);
    // modulo zero overflows on every tick, so a pending clear always loses
    wr(`OFF_STATUS, 32'h30);
    wr(`OFF_MOD_HI, 32'h0);
    wr(`OFF_MOD_LO, 32'h0);
    wr(`OFF_STATUS, 32'h0);
    cyc(4);
    rd(`OFF_STATUS, 32'h80);
    wr(`OFF_STATUS, 32'h0);
    rd(`OFF_STATUS, 32'h80);
    wr(`OFF_STATUS, 32'h20);
    rd(`OFF_STATUS, 32'ha0);
    brk <= 1'b1;
    wr(`OFF_STATUS, 32'h20);
    rd(`OFF_STATUS, 32'ha0);
    brk <= 1'b0;
    wr(`OFF_STATUS, 32'h20);
    rd(`OFF_STATUS, 32'h20);
    wr(`OFF_STATUS, 32'h0);
    cyc(3);
    wr(`OFF_STATUS, 32'h20);
    brk <= 1'b1;
    bce <= 1'b1;
    rd(`OFF_STATUS, 32'ha0);
    wr(`OFF_STATUS, 32'h20);
    brk <= 1'b0;
    bce <= 1'b0;
    rd(`OFF_STATUS, 32'h20);
    wr(`OFF_MOD_HI, 32'h0);
    wr(`OFF_STATUS, 32'h0);
    cyc(10);
    wr(`OFF_STATUS, 32'h20);
    rd(`OFF_STATUS, 32'h20);
    wr(`OFF_MOD_LO, 32'h0);
    wr(`OFF_STATUS, 32'h0);
    cyc(3);
    wr(`OFF_STATUS, 32'h20);
    rd(`OFF_STATUS, 32'ha0);
    wr(`OFF_STATUS, 32'h30);
    wr(`OFF_MOD_HI, 32'hff);
    wr(`OFF_MOD_LO, 32'hff);
    wr(`OFF_STATUS, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      if (i == 0) clk_en <= 1'b0;
      else if (i == 1) stop_mode <= 1'b1;
      else brk <= 1'b1;
      cyc(2);
      snap = count_value;
      cyc(10);
      chk(count_value, snap);
      {clk_en, stop_mode, brk} <= 3'b100;
      cyc(3);
      chk(count_value !== snap, 1'b1);
    end
    wait_mode <= 1'b1;
    snap = count_value;
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(err, 1'b1);
    chk(rdata, 32'h0);
    chk(count_value !== snap, 1'b1);
    wait_mode <= 1'b0;
    wr(`OFF_STATUS, 32'h20);
    cyc(2);
    snap = count_value;
    rd(`OFF_CNT_HI, snap[15:8]);
    wr(`OFF_STATUS, 32'h0);
    cyc(300);
    wr(`OFF_STATUS, 32'h20);
    apb(1'b0, `OFF_CNT_HI, 32'h0);
    rd(`OFF_CNT_LO, snap[7:0]);
    snap = count_value;
    rd(`OFF_CNT_LO, snap[7:0]);
    wr(`OFF_STATUS, 32'h30);
    rd(`OFF_CNT_HI, 32'h0);
    rd(`OFF_CNT_LO, 32'h0);
    rd(`OFF_STATUS, 32'h20);
    // random channel modes and events
    mode = 6'($urandom);
    exp_fl = 6'($urandom);
    snap = 16'($urandom);
    wr(`OFF_CH_IRQ_EN, 32'h3f);
    wr(`OFF_CH_MODE, mode);
    cyc(1);
    chk(cmp_mode, mode);
    wr(`OFF_STATUS, 32'h0);
    cap_ev <= exp_fl;
    cmp_ev <= snap[5:0];
    @(posedge clk);
    {cap_ev, cmp_ev} <= '0;
    exp_fl = (exp_fl & ~mode) | (snap[5:0] & mode);
    cyc(2);
    rd(`OFF_CH_FLAGS, exp_fl);
    chk(channel_irq, exp_fl);
    chk(timer_irq, exp_fl != 0);
    wr(`OFF_STATUS, 32'h20);
    rd(`OFF_CH_FLAGS, exp_fl);
    wr(`OFF_CH_FLAGS, 32'h0);
    rd(`OFF_CH_FLAGS, 32'h0);
    wr(`OFF_CH_MODE, 32'h0);
    cap_ev <= 6'h3f;
    @(posedge clk);
    cap_ev <= 6'h0;
    cyc(2);
    rd(`OFF_CH_FLAGS, 32'h0);
    wr(`OFF_CH_MODE, 32'h1c0);
    cyc(1);
    chk(buf_mode, 3'h7);
    // buffered pairs leave the odd channels idle
    wr(`OFF_STATUS, 32'h0);
    cap_ev <= 6'h3f;
    @(posedge clk);
    cap_ev <= 6'h0;
    cyc(2);
    rd(`OFF_CH_FLAGS, 32'h15);
    results();
  end
endmodule // tb_modulo_timer_control
